/* File: hdl/tib_defs.svh */
// Purpose: constants for the timer interrupt flag bank
// Assumes: AHB-Lite, 32-bit words, byte addresses as printed
// Notes: all 32 address bits decode the bank
`ifndef TIB_DEFS_SVH
`define TIB_DEFS_SVH
`define TIB_PEND1_ADDR  32'h4000A800
`define TIB_PEND2_ADDR  32'h4000A804
`define TIB_MISS1_ADDR  32'h4000A818
`define TIB_MISS2_ADDR  32'h4000A81C
`define TIB_ENA1_ADDR   32'h4000A840
`define TIB_ENA2_ADDR   32'h4000A844
`define TIB_SRC_MASK    7'h5F
`define TIB_CC_MASK     7'h1E
`define TIB_MISS_LSB    9
`define TIB_RESET_VAL   32'h00000000
`endif

/* File: hdl/tib_pkg.sv */
// Purpose: types for the timer interrupt flag bank
// Assumes: two timer instances
// Notes: event strobe bundle per timer
package tib_pkg;
  typedef struct packed {
    logic trig;
    logic cc4;
    logic cc3;
    logic cc2;
    logic cc1;
    logic upd;
  } tib_evt_s;
  typedef enum logic [2:0] {
    REG_NONE  = 3'h0,
    REG_PEND1 = 3'h1,
    REG_PEND2 = 3'h2,
    REG_MISS1 = 3'h3,
    REG_MISS2 = 3'h4,
    REG_ENA1  = 3'h5,
    REG_ENA2  = 3'h6
  } tib_reg_e;
endpackage

/* File: hdl/tib_timer_flags.sv */
// Purpose: flag, missed and enable state for one timer
// Assumes: event strobes one cycle, synchronous to clock
// Notes: set wins over write-one-to-clear
`timescale 1ns/1ps
`include "tib_defs.svh"
module tib_timer_flags (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // Event strobes
  input  wire tib_pkg::tib_evt_s evt,
  // Register writes
  input  wire logic             wrPend,
  input  wire logic             wrMiss,
  input  wire logic             wrEna,
  input  wire logic [31:0]      wdata,
  // State
  output logic      [6:0]       pend,
  output logic      [3:0]       miss,
  output logic      [6:0]       ena
);
  logic [6:0] pend_ff;
  logic [3:0] miss_ff;
  logic [6:0] ena_ff;
  wire  [6:0] evtVec;
  wire  [6:0] pendClr;
  wire  [3:0] missClr;
  wire  [3:0] missSet;
  wire  [6:0] nxt_pend;
  wire  [3:0] nxt_miss;
  wire  [6:0] nxt_ena;

  assign evtVec  = {evt.trig, 1'b0, evt.cc4, evt.cc3, evt.cc2, evt.cc1,
                    evt.upd};
  assign pendClr = wrPend ? wdata[6:0] : 7'h00;
  assign missClr = wrMiss ? wdata[12:9] : 4'h0;
  // Already pending capture event counts as lost
  assign missSet = evtVec[4:1] & pend_ff[4:1];
  assign nxt_pend = ((pend_ff & ~pendClr) | evtVec) & `TIB_SRC_MASK;
  assign nxt_miss = (miss_ff & ~missClr) | missSet;
  assign nxt_ena  = wrEna ? (wdata[6:0] & `TIB_SRC_MASK) : ena_ff;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pend_ff <= 7'h00;
      miss_ff <= 4'h0;
      ena_ff  <= 7'h00;
    end else begin
      pend_ff <= nxt_pend;
      miss_ff <= nxt_miss;
      ena_ff  <= nxt_ena;
    end
  end

  assign pend = pend_ff;
  assign miss = miss_ff;
  assign ena  = ena_ff;
endmodule

/* File: hdl/tib_flag_bank.sv */
// Purpose: AHB-Lite slave with two timer interrupt flag sets
// Assumes: single word transfers, zero wait states
// Notes: irq outputs are level, high on enabled pending flag
`timescale 1ns/1ps
`include "tib_defs.svh"
module tib_flag_bank (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // AHB-Lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic             hready,
  input  wire logic [31:0]      hwdata,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  // Timer events
  input  wire tib_pkg::tib_evt_s evtTim1,
  input  wire tib_pkg::tib_evt_s evtTim2,
  // Interrupts
  output logic                  irqTim1,
  output logic                  irqTim2
);
  tib_pkg::tib_reg_e regSel_ff;
  logic [31:0]       hrdata_ff;
  logic [6:0]        pend1;
  logic [6:0]        pend2;
  logic [3:0]        miss1;
  logic [3:0]        miss2;
  logic [6:0]        ena1;
  logic [6:0]        ena2;
  logic              wrPhase_ff;
  tib_pkg::tib_reg_e nxt_regSel;
  wire               addrValid;
  wire  [31:0]       rdMux;

  function automatic tib_pkg::tib_reg_e decodeAddr(input logic [31:0] a);
    case (a)
      `TIB_PEND1_ADDR: decodeAddr = tib_pkg::REG_PEND1;
      `TIB_PEND2_ADDR: decodeAddr = tib_pkg::REG_PEND2;
      `TIB_MISS1_ADDR: decodeAddr = tib_pkg::REG_MISS1;
      `TIB_MISS2_ADDR: decodeAddr = tib_pkg::REG_MISS2;
      `TIB_ENA1_ADDR:  decodeAddr = tib_pkg::REG_ENA1;
      `TIB_ENA2_ADDR:  decodeAddr = tib_pkg::REG_ENA2;
      default:         decodeAddr = tib_pkg::REG_NONE;
    endcase
  endfunction

  assign addrValid  = hsel & htrans[1] & hready;
  assign nxt_regSel = addrValid ? decodeAddr(haddr) : tib_pkg::REG_NONE;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      regSel_ff  <= tib_pkg::REG_NONE;
      wrPhase_ff <= 1'b0;
    end else begin
      regSel_ff  <= nxt_regSel;
      wrPhase_ff <= addrValid & hwrite;
    end
  end

  // Writes land in the data phase, where hwdata stands
  wire wr = wrPhase_ff;
  tib_timer_flags uTim1 (
    .clock  (clock),
    .rst    (rst),
    .evt    (evtTim1),
    .wrPend (wr && regSel_ff == tib_pkg::REG_PEND1),
    .wrMiss (wr && regSel_ff == tib_pkg::REG_MISS1),
    .wrEna  (wr && regSel_ff == tib_pkg::REG_ENA1),
    .wdata  (hwdata),
    .pend   (pend1),
    .miss   (miss1),
    .ena    (ena1)
  );
  tib_timer_flags uTim2 (
    .clock  (clock),
    .rst    (rst),
    .evt    (evtTim2),
    .wrPend (wr && regSel_ff == tib_pkg::REG_PEND2),
    .wrMiss (wr && regSel_ff == tib_pkg::REG_MISS2),
    .wrEna  (wr && regSel_ff == tib_pkg::REG_ENA2),
    .wdata  (hwdata),
    .pend   (pend2),
    .miss   (miss2),
    .ena    (ena2)
  );

  // Reserved fields read as zero; software must not rely on them
  assign rdMux =
    (nxt_regSel == tib_pkg::REG_PEND1) ? {25'h0000000, pend1} :
    (nxt_regSel == tib_pkg::REG_PEND2) ? {25'h0000000, pend2} :
    (nxt_regSel == tib_pkg::REG_MISS1) ? {19'h00000, miss1, 9'h000} :
    (nxt_regSel == tib_pkg::REG_MISS2) ? {19'h00000, miss2, 9'h000} :
    (nxt_regSel == tib_pkg::REG_ENA1)  ? {25'h0000000, ena1} :
    (nxt_regSel == tib_pkg::REG_ENA2)  ? {25'h0000000, ena2} :
                                         `TIB_RESET_VAL;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hrdata_ff <= `TIB_RESET_VAL;
    end else if (addrValid & ~hwrite) begin
      hrdata_ff <= rdMux;
    end
  end

  assign hrdata    = hrdata_ff;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign irqTim1   = |(pend1 & ena1);
  assign irqTim2   = |(pend2 & ena2);
endmodule

/* File: sim/tib_chk.sv */
// Purpose: port assertions for tib_flag_bank
// Assumes: zero wait, write lands one cycle after address phase
// Notes: bound below
`timescale 1ns/1ps
module tib_chk (
  // Clock and reset
  input wire logic              clock,
  input wire logic              rst,
  // Bus
  input wire logic              hsel,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic              hready,
  input wire logic [31:0]       hrdata,
  input wire logic              hreadyout,
  input wire logic              hresp,
  // Events and interrupts
  input wire tib_pkg::tib_evt_s evtTim1,
  input wire tib_pkg::tib_evt_s evtTim2,
  input wire logic              irqTim1,
  input wire logic              irqTim2
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  wire taken = hsel && htrans[1] && hready;
  wire wr = taken && hwrite;
  sequence rdTaken;
    taken && !hwrite;
  endsequence
  rdy_ok_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  rd_hold_a: assert property (!(taken && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");
  rsvd_zero_a: assert property (rdTaken |=>
    hrdata[31:13] == 19'h00000 && hrdata[8:7] == 2'h0 && !hrdata[5])
    else $error("reserved read bits not zero");
  irq1_rise_a: assert property ($rose(irqTim1) |->
    $past(evtTim1) != 0 || $past(wr, 2)) else $error("irq1 rose");
  irq2_rise_a: assert property ($rose(irqTim2) |->
    $past(evtTim2) != 0 || $past(wr, 2)) else $error("irq2 rose");
  irq1_fall_a: assert property ($fell(irqTim1) |-> $past(wr, 2))
    else $error("irq1 fell without write");
  irq2_fall_a: assert property ($fell(irqTim2) |-> $past(wr, 2))
    else $error("irq2 fell without write");
  irq1_hold_a: assert property (irqTim1 && !$past(wr) |=> irqTim1)
    else $error("irq1 dropped");
  irq2_hold_a: assert property (irqTim2 && !$past(wr) |=> irqTim2)
    else $error("irq2 dropped");
endmodule
bind tib_flag_bank tib_chk chk (.*);

/* File: sim/tb.sv */
// Purpose: self-checking bench for tib_flag_bank
// Assumes: AHB-Lite master, single words
// Notes: reserved fields masked on flag reads
`timescale 1ns/1ps
module tb;
  logic              clock = 0, rst = 1, hsel = 0, hwrite = 0;
  logic [31:0]       haddr = '0, hwdata = '0, r, hrdata;
  logic [1:0]        htrans = '0;
  logic              hreadyout, hresp, irqTim1, irqTim2;
  tib_pkg::tib_evt_s evtTim1 = '0, evtTim2 = '0;
  int                error_cnt = 0, checked = 0;
  tib_flag_bank uut (.clock(clock), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .evtTim1(evtTim1),
    .evtTim2(evtTim2), .irqTim1(irqTim1), .irqTim2(irqTim2));
  initial forever #20 clock = ~clock;
  task end_sim;
    if (error_cnt == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic xfer(input logic [31:0] a, d, input logic w);
    int n = 0;
    hsel <= 1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clock); while (hreadyout !== 1 && ++n < 50);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1 && ++n < 50);
    r = hrdata;
    if (n >= 50) begin
      error_cnt++;
      end_sim;
    end
  endtask
  task pulse(input tib_pkg::tib_evt_s a, b);
    evtTim1 <= a;
    evtTim2 <= b;
    @(posedge clock);
    evtTim1 <= '0;
    evtTim2 <= '0;
    @(posedge clock);
  endtask
  task t_reset;
    logic [31:0] a[7] = '{32'h4000A800, 32'h4000A804, 32'h4000A818,
      32'h4000A81C, 32'h4000A840, 32'h4000A844, 32'h4000A808};
    foreach (a[i]) begin
      xfer(a[i], 0, 0);
      chk("reset read", r, 0);
    end
  endtask
  task t_enable;
    xfer(32'h4000A840, 32'hFFFFFFFF, 1);
    xfer(32'h4000A840, 0, 0);
    chk("ena1", r, 32'h5F);
    xfer(32'h4000A840, 0, 1);
    xfer(32'h4000A840, 0, 0);
    chk("ena1 clr", r, 0);
  endtask
  task t_events;
    pulse(6'h3F, 6'h20);
    xfer(32'h4000A800, 0, 0);
    chk("pend1", r & 32'h5F, 32'h5F);
    pulse(6'h1E, 6'h0);
    xfer(32'h4000A818, 0, 0);
    chk("miss1", r & 32'h1E00, 32'h1E00);
    xfer(32'h4000A804, 0, 0);
    chk("pend2", r & 32'h5F, 32'h40);
    xfer(32'h4000A840, 2, 1);
    xfer(32'h4000A818, 32'h1E00, 1);
    chk("irq1 on", irqTim1, 1);
    xfer(32'h4000A840, 0, 1);
    xfer(32'h4000A818, 0, 0);
    chk("miss1 clr", r & 32'h1E00, 0);
    chk("irq1 masked", irqTim1, 0);
    xfer(32'h4000A800, 32'h5F, 1);
    xfer(32'h4000A800, 0, 0);
    chk("pend1 clr", r & 32'h5F, 0);
    xfer(32'h4000A804, 32'h40, 1);
    xfer(32'h4000A844, 1, 1);
    pulse(6'h0, 6'h01);
    chk("irq2 on", irqTim2, 1);
  endtask
  task automatic t_setwins;
    int n = 0;
    hsel <= 1;
    haddr <= 32'h4000A800;
    hwrite <= 1;
    htrans <= 2'h2;
    do @(posedge clock); while (hreadyout !== 1 && ++n < 50);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= 32'h1;
    evtTim1 <= 6'h01;
    do @(posedge clock); while (hreadyout !== 1 && ++n < 50);
    evtTim1 <= '0;
    if (n >= 50) begin
      error_cnt++;
      end_sim;
    end
    xfer(32'h4000A800, 0, 0);
    chk("pend1 set wins", r & 32'h5F, 32'h1);
    xfer(32'h4000A818, 0, 0);
    chk("miss1 no upd", r & 32'h1E00, 0);
    pulse(6'h0, 6'h02);
    pulse(6'h0, 6'h02);
    xfer(32'h4000A81C, 0, 0);
    chk("miss2 cc1", r & 32'h1E00, 32'h200);
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst <= 0;
    @(posedge clock);
    t_reset;
    t_enable;
    t_events;
    t_setwins;
    end_sim;
  end
endmodule
